// File: hw/dual_channel_bus_master_dma.v
/*
 Two-channel bus-master DMA engine: video/graphics channel and command channel,
 with a plain register port. Assumes system memory, the port output FIFO, video
 memory read data and the 3D engine are handshake partners on the same clock.
*/
`timescale 1ns/1ps
`include "dma_defines.vh"
module dual_channel_bus_master_dma (
    // Clock, reset, enable.
    input  wire        ref_clk,
    input  wire        rstn,
    input  wire        clk_en,
    // Register port.
    input  wire [15:0] reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_write,
    input  wire        reg_read,
    output reg  [31:0] reg_rdata,
    // Video channel memory bus.
    output wire        vid_req,
    output wire        vid_req_write,
    output wire [31:0] vid_req_addr,
    output wire [31:0] vid_req_wdata,
    input  wire        vid_ack,
    input  wire [31:0] vid_rdata,
    // Command channel memory bus (reads only).
    output wire        cmd_req,
    output wire [31:0] cmd_req_addr,
    input  wire        cmd_ack,
    input  wire [31:0] cmd_rdata,
    // Local peripheral port output FIFO.
    output reg         port_valid,
    output reg  [31:0] port_data,
    output reg         port_to_video,
    output reg         port_decimate,
    input  wire        port_ready,
    // Video memory read data source.
    input  wire        vmem_valid,
    input  wire [31:0] vmem_data,
    output wire        vmem_ready,
    // 3D engine command stream.
    output reg         engine_valid,
    output reg  [31:0] engine_data,
    input  wire        engine_ready,
    // Done status and interrupt request.
    output wire        irq
);
    localparam V_IDLE = 2'd0;
    localparam V_MEM  = 2'd1;
    localparam V_PUSH = 2'd2;
    localparam V_VMEM = 2'd3;

    localparam C_IDLE = 1'b0;
    localparam C_WAIT = 1'b1;

    reg  [31:2] video_addr;
    reg         video_dir;
    reg  [23:2] video_len;
    reg         video_channel_go;

    reg  [31:12] cmd_base;
    reg         command_buffer_size;
    reg  [15:2] write_ptr;
    reg  [15:2] read_ptr;
    reg         command_channel_go;

    reg         host_transfer_done_status;
    reg         command_transfer_done_status;
    reg         host_transfer_done_irq_enable;
    reg         command_transfer_done_irq_enable;
    reg         read_pointer_reset;

    reg  [1:0]  vstate;
    reg         cstate;
    reg  [31:2] cur_addr;
    reg  [23:2] remaining;
    reg         vid_start;
    reg         cmd_start;
    reg  [31:0] cmd_fetch_addr;
    reg  [15:2] next_read_ptr;
    reg  [31:0] vmem_hold;

    wire        vid_busy;
    wire        vid_done;
    wire        cmd_busy;
    wire        cmd_done;
    wire        wr_video_en;
    wire        wr_cmd_wptr;
    wire        wr_status;
    wire        video_finish;
    wire        cmd_finish;
    wire        ring_empty;

    assign wr_video_en = reg_write && reg_addr == `ADDR_VIDEO_ENABLE;
    assign wr_cmd_wptr = reg_write && reg_addr == `ADDR_CMD_WRITE_PTR;
    assign wr_status   = reg_write && reg_addr == `ADDR_DMA_STATUS;
    assign ring_empty  = command_buffer_size ? (read_ptr == write_ptr) : (read_ptr[11:2] == write_ptr[11:2]);

    // Fetch address and pointer wrap depend on buffer size.
    always @* begin
        cmd_fetch_addr = 32'h0;
        next_read_ptr  = read_ptr + 14'h1;
        if (command_buffer_size) begin
            cmd_fetch_addr = {cmd_base[31:16], read_ptr[15:2], 2'b00};
        end else begin
            cmd_fetch_addr = {cmd_base[31:12], read_ptr[11:2], 2'b00};
            next_read_ptr  = {4'h0, next_read_ptr[11:2]};
        end
    end

    // One request port per channel, so neither channel waits on the other.
    bus_port vid_port (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .clk_en    (clk_en),
        .start     (vid_start),
        .write     (video_dir),
        .addr      ({cur_addr, 2'b00}),
        .wdata     (vmem_hold),
        .req       (vid_req),
        .req_write (vid_req_write),
        .req_addr  (vid_req_addr),
        .req_wdata (vid_req_wdata),
        .ack       (vid_ack),
        .busy      (vid_busy),
        .done      (vid_done)
    );

    bus_port cmd_port (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .clk_en    (clk_en),
        .start     (cmd_start),
        .write     (1'b0),
        .addr      (cmd_fetch_addr),
        .wdata     (32'h0),
        .req       (cmd_req),
        .req_write (),
        .req_addr  (cmd_req_addr),
        .req_wdata (),
        .ack       (cmd_ack),
        .busy      (cmd_busy),
        .done      (cmd_done)
    );

    assign vmem_ready   = (vstate == V_VMEM) && !vid_busy && !vid_start;
    assign video_finish = vid_done && remaining == 22'h0;
    assign cmd_finish   = cmd_done && !wr_cmd_wptr
                        && next_read_ptr == (command_buffer_size ? write_ptr : {4'h0, write_ptr[11:2]});
    assign irq = (host_transfer_done_status & host_transfer_done_irq_enable)
               | (command_transfer_done_status & command_transfer_done_irq_enable);

    // Video channel sequencer.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            vstate     <= V_IDLE;
            cur_addr   <= 30'h0;
            remaining  <= 22'h0;
            vid_start  <= 1'b0;
            port_valid <= 1'b0;
            port_data  <= `RESET_WORD;
            vmem_hold  <= `RESET_WORD;
        end else if (clk_en) begin
            vid_start <= 1'b0;
            case (vstate)
                V_IDLE: begin
                    if (video_channel_go && !wr_video_en) begin
                        cur_addr  <= video_addr;
                        remaining <= video_len;
                        if (video_dir) begin
                            vstate <= V_VMEM;
                        end else begin
                            vstate    <= V_MEM;
                            vid_start <= 1'b1;
                        end
                    end
                end
                V_MEM: begin
                    if (vid_done) begin
                        port_valid <= 1'b1;
                        port_data  <= vid_rdata;
                        vstate     <= V_PUSH;
                    end
                end
                V_PUSH: begin
                    if (port_ready) begin
                        port_valid <= 1'b0;
                        if (remaining == 22'h0) begin
                            vstate <= V_IDLE;
                        end else begin
                            remaining <= remaining - 22'h1;
                            cur_addr  <= cur_addr + 30'h1;
                            vid_start <= 1'b1;
                            vstate    <= V_MEM;
                        end
                    end
                end
                V_VMEM: begin
                    if (vmem_valid && vmem_ready) begin
                        vmem_hold <= vmem_data;
                        vid_start <= 1'b1;
                    end else if (vid_done) begin
                        if (remaining == 22'h0) begin
                            vstate <= V_IDLE;
                        end else begin
                            remaining <= remaining - 22'h1;
                            cur_addr  <= cur_addr + 30'h1;
                        end
                    end
                end
                default: vstate <= V_IDLE;
            endcase
        end
    end

    // Command channel: fetch, hand to the engine, advance.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cstate       <= C_IDLE;
            cmd_start    <= 1'b0;
            engine_valid <= 1'b0;
            engine_data  <= `RESET_WORD;
        end else if (clk_en) begin
            cmd_start <= 1'b0;
            if (engine_valid && engine_ready) begin
                engine_valid <= 1'b0;
            end
            case (cstate)
                C_IDLE: begin
                    if (command_channel_go && !ring_empty && !engine_valid && !cmd_busy) begin
                        cmd_start <= 1'b1;
                        cstate    <= C_WAIT;
                    end
                end
                C_WAIT: begin
                    if (cmd_done) begin
                        engine_valid <= 1'b1;
                        engine_data  <= cmd_rdata;
                        cstate       <= C_IDLE;
                    end
                end
                default: cstate <= C_IDLE;
            endcase
        end
    end

    // Register file; hardware set of go-clear and done flags wins over software.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            video_addr                       <= 30'h0;
            video_dir                        <= 1'b0;
            video_len                        <= 22'h0;
            video_channel_go                 <= 1'b0;
            cmd_base                         <= 20'h0;
            command_buffer_size              <= 1'b0;
            write_ptr                        <= 14'h0;
            read_ptr                         <= 14'h0;
            command_channel_go               <= 1'b0;
            host_transfer_done_status        <= 1'b0;
            command_transfer_done_status     <= 1'b0;
            host_transfer_done_irq_enable    <= 1'b0;
            command_transfer_done_irq_enable <= 1'b0;
            read_pointer_reset               <= 1'b0;
            port_to_video                    <= 1'b0;
            port_decimate                    <= 1'b0;
        end else if (clk_en) begin
            if (reg_write) begin
                case (reg_addr)
                    `ADDR_VIDEO_START: begin
                        video_addr <= reg_wdata[31:2];
                        video_dir  <= reg_wdata[`BIT_DIRECTION];
                    end
                    `ADDR_VIDEO_LENGTH: video_len <= reg_wdata[23:2];
                    `ADDR_VIDEO_ENABLE: video_channel_go <= reg_wdata[0];
                    `ADDR_CMD_BASE: begin
                        cmd_base            <= reg_wdata[31:12];
                        command_buffer_size <= reg_wdata[`BIT_BUFFER_SIZE];
                    end
                    // The pointer is taken only with the updated flag set.
                    `ADDR_CMD_WRITE_PTR: if (reg_wdata[`BIT_WPTR_UPDATED]) write_ptr <= reg_wdata[15:2];
                    `ADDR_CMD_READ_PTR: read_ptr <= reg_wdata[15:2];
                    `ADDR_CMD_ENABLE: command_channel_go <= reg_wdata[0];
                    `ADDR_DMA_CONTROL: begin
                        host_transfer_done_irq_enable    <= reg_wdata[`BIT_HOST_IRQ_EN];
                        command_transfer_done_irq_enable <= reg_wdata[`BIT_CMD_IRQ_EN];
                        read_pointer_reset               <= reg_wdata[`BIT_PTR_RESET];
                        port_to_video                    <= reg_wdata[`BIT_ROUTE_VIDEO];
                        port_decimate                    <= reg_wdata[`BIT_DECIMATE];
                    end
                    default: ;
                endcase
            end
            // Write-one-to-clear of done flags.
            if (wr_status && reg_wdata[`BIT_HOST_DONE]) begin
                host_transfer_done_status <= 1'b0;
            end
            if (wr_status && reg_wdata[`BIT_CMD_DONE]) begin
                command_transfer_done_status <= 1'b0;
            end

            // Advance the read pointer after each fetched doubleword.
            if (cmd_done) begin
                read_ptr <= next_read_ptr;
            end
            if (read_pointer_reset) begin
                read_ptr <= 14'h0;
            end
            if ((vstate == V_PUSH && port_ready && remaining == 22'h0) || (vstate == V_VMEM && video_finish)) begin
                video_channel_go          <= 1'b0;
                host_transfer_done_status <= 1'b1;
            end
            if (cmd_finish) begin
                command_transfer_done_status <= 1'b1;
            end
        end
    end

    // Read data stands for the cycle after the strobe; reserved bits read zero.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= `RESET_WORD;
        end else if (clk_en) begin
            reg_rdata <= `RESET_WORD;
            if (reg_read) begin
                case (reg_addr)
                    `ADDR_VIDEO_START:   reg_rdata <= {video_addr[31:2], video_dir, 1'b0};
                    `ADDR_VIDEO_LENGTH:  reg_rdata <= {8'h0, video_len, 2'b00};
                    `ADDR_VIDEO_ENABLE:  reg_rdata <= {31'h0, video_channel_go};
                    `ADDR_CMD_BASE:      reg_rdata <= {cmd_base, 10'h0, command_buffer_size, 1'b0};
                    `ADDR_CMD_WRITE_PTR: reg_rdata <= {16'h0, write_ptr, 2'b00};
                    `ADDR_CMD_READ_PTR:  reg_rdata <= {16'h0, read_ptr, 2'b00};
                    `ADDR_CMD_ENABLE:    reg_rdata <= {31'h0, command_channel_go};
                    `ADDR_DMA_STATUS:    reg_rdata <= {30'h0, command_transfer_done_status,
                                                       host_transfer_done_status};
                    `ADDR_DMA_CONTROL:   reg_rdata <= {27'h0, port_decimate, port_to_video, read_pointer_reset,
                                                       command_transfer_done_irq_enable,
                                                       host_transfer_done_irq_enable};
                    default:             reg_rdata <= `RESET_WORD;
                endcase
            end
        end
    end
endmodule // dual_channel_bus_master_dma

// File: hw/dma_defines.vh
/*
 Register offsets, field positions and reset values for the two-channel
 bus-master DMA engine. Assumes a 32-bit register port addressed by byte offset.
*/
`ifndef DMA_DEFINES_VH
`define DMA_DEFINES_VH
`define ADDR_VIDEO_START     16'h8580
`define ADDR_VIDEO_LENGTH    16'h8584
`define ADDR_VIDEO_ENABLE    16'h8588
`define ADDR_CMD_BASE        16'h8590
`define ADDR_CMD_WRITE_PTR   16'h8594
`define ADDR_CMD_READ_PTR    16'h8598
`define ADDR_CMD_ENABLE      16'h859c
`define ADDR_DMA_STATUS      16'h85a0
`define ADDR_DMA_CONTROL     16'h85a4
`define BIT_DIRECTION        1
`define BIT_BUFFER_SIZE      1
`define BIT_WPTR_UPDATED     16
`define BIT_HOST_DONE        0
`define BIT_CMD_DONE         1
`define BIT_HOST_IRQ_EN      0
`define BIT_CMD_IRQ_EN       1
`define BIT_PTR_RESET        2
`define BIT_ROUTE_VIDEO      3
`define BIT_DECIMATE         4
`define RESET_WORD           32'h0000_0000
`endif

// File: hw/bus_port.v
/*
 One bus-master request port: holds a request until the bus accepts it.
 Assumes the memory side answers with a single-cycle ack.
*/
`timescale 1ns/1ps
module bus_port (
    // Clock, reset, enable.
    input  wire        ref_clk,
    input  wire        rstn,
    input  wire        clk_en,
    // Request from the channel.
    input  wire        start,
    input  wire        write,
    input  wire [31:0] addr,
    input  wire [31:0] wdata,
    // Memory bus side.
    output reg         req,
    output reg         req_write,
    output reg  [31:0] req_addr,
    output reg  [31:0] req_wdata,
    input  wire        ack,
    // Status to the channel.
    output wire        busy,
    output wire        done
);
    // A held request drops on its ack; a new start is only accepted when idle.
    assign busy = req;
    assign done = req & ack;
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            req       <= 1'b0;
            req_write <= 1'b0;
            req_addr  <= 32'h0;
            req_wdata <= 32'h0;
        end else if (clk_en) begin
            if (req && ack) begin
                req <= 1'b0;
            end else if (!req && start) begin
                req       <= 1'b1;
                req_write <= write;
                req_addr  <= addr;
                req_wdata <= wdata;
            end
        end
    end
endmodule // bus_port

// File: bench/dma_monitor.sv
/*
 Port-level assertions for the two-channel DMA engine.
 Assumes one clock domain, single-cycle acks and held valid/ready streams.
*/
`timescale 1ns/1ps
module dma_monitor (
    // Clock and reset.
    input wire        ref_clk,
    input wire        rstn,
    // Video memory bus.
    input wire        vid_req,
    input wire        vid_req_write,
    input wire [31:0] vid_req_addr,
    input wire [31:0] vid_req_wdata,
    input wire        vid_ack,
    input wire [31:0] vid_rdata,
    // Command memory bus.
    input wire        cmd_req,
    input wire [31:0] cmd_req_addr,
    input wire        cmd_ack,
    input wire [31:0] cmd_rdata,
    // Streams.
    input wire        port_valid,
    input wire [31:0] port_data,
    input wire        port_ready,
    input wire        vmem_valid,
    input wire [31:0] vmem_data,
    input wire        vmem_ready,
    input wire        engine_valid,
    input wire [31:0] engine_data,
    input wire        engine_ready
);
    reg [31:0] vid_word;
    reg [31:0] cmd_word;
    reg [31:0] vmem_word;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // Remember each word taken so its later hand-off can be compared.
    always @(posedge ref_clk) begin
        if (vid_ack) vid_word <= vid_rdata;
        if (cmd_ack) cmd_word <= cmd_rdata;
        if (vmem_valid && vmem_ready) vmem_word <= vmem_data;
    end
    sequence s_vid_take; vid_ack && !vid_req_write; endsequence
    sequence s_port_show; port_valid && port_data == vid_word; endsequence
    sequence s_cmd_take; cmd_ack; endsequence
    sequence s_engine_show; engine_valid && engine_data == cmd_word; endsequence
    property p_vid_hold; vid_req && !vid_ack |=> vid_req && $stable(vid_req_addr) && $stable(vid_req_wdata); endproperty
    a_vid_hold: assert property (p_vid_hold) else $error("video request dropped or changed before ack");
    property p_cmd_hold; cmd_req && !cmd_ack |=> cmd_req && $stable(cmd_req_addr); endproperty
    a_cmd_hold: assert property (p_cmd_hold) else $error("command request dropped or changed before ack");
    property p_cmd_align; cmd_req |-> cmd_req_addr[1:0] == 2'h0; endproperty
    a_cmd_align: assert property (p_cmd_align) else $error("command fetch address not doubleword aligned");
    property p_port_hold; port_valid && !port_ready |=> port_valid && $stable(port_data); endproperty
    a_port_hold: assert property (p_port_hold) else $error("port word dropped before ready");
    property p_engine_hold; engine_valid && !engine_ready |=> engine_valid && $stable(engine_data); endproperty
    a_engine_hold: assert property (p_engine_hold) else $error("engine word dropped before ready");
    property p_cmd_to_engine; s_cmd_take |=> ##[0:2] s_engine_show; endproperty
    a_cmd_to_engine: assert property (p_cmd_to_engine) else $error("fetched word not passed to engine");
    property p_vid_to_port; s_vid_take |=> ##[0:2] s_port_show; endproperty
    a_vid_to_port: assert property (p_vid_to_port) else $error("read word not passed to port");
    property p_vmem_to_sys; vmem_valid && vmem_ready |=> ##[0:2] (vid_req && vid_req_write && vid_req_wdata == vmem_word); endproperty
    a_vmem_to_sys: assert property (p_vmem_to_sys) else $error("video memory word not written out");
endmodule // dma_monitor

bind dual_channel_bus_master_dma dma_monitor u_mon (.ref_clk(ref_clk), .rstn(rstn), .vid_req(vid_req),
    .vid_req_write(vid_req_write), .vid_req_addr(vid_req_addr), .vid_req_wdata(vid_req_wdata), .vid_ack(vid_ack),
    .vid_rdata(vid_rdata), .cmd_req(cmd_req), .cmd_req_addr(cmd_req_addr), .cmd_ack(cmd_ack), .cmd_rdata(cmd_rdata),
    .port_valid(port_valid), .port_data(port_data), .port_ready(port_ready), .vmem_valid(vmem_valid),
    .vmem_data(vmem_data), .vmem_ready(vmem_ready), .engine_valid(engine_valid), .engine_data(engine_data),
    .engine_ready(engine_ready));

// File: bench/sys_mem_model.sv
/*
 System memory seen over the two request/ack buses.
 Assumes requests are held until ack; read data is the address XOR a fixed mask.
*/
`timescale 1ns/1ps
module sys_mem_model (
    // Clock and reset.
    input wire        ref_clk,
    input wire        rstn,
    // Video bus.
    input wire        vid_req,
    input wire        vid_req_write,
    input wire [31:0] vid_req_addr,
    output reg        vid_ack,
    output reg [31:0] vid_rdata,
    // Command bus.
    input wire        cmd_req,
    input wire [31:0] cmd_req_addr,
    output reg        cmd_ack,
    output reg [31:0] cmd_rdata
);
    reg  [1:0] vid_wait;
    reg  [1:0] cmd_wait;
    wire       vid_hit = vid_req && !vid_ack && vid_wait == 2'h0;
    wire       cmd_hit = cmd_req && !cmd_ack && cmd_wait == 2'h0;
    // Free-running phase counters give latencies of zero to three cycles.
    // Outside an ack the data lines toggle, so stale words never pass as fresh.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            vid_ack   <= 1'b0;
            cmd_ack   <= 1'b0;
            vid_wait  <= 2'h0;
            cmd_wait  <= 2'h1;
            vid_rdata <= 32'h0;
            cmd_rdata <= 32'h0;
        end else begin
            vid_wait  <= vid_wait + 2'h1;
            cmd_wait  <= cmd_wait + 2'h3;
            vid_ack   <= vid_hit;
            cmd_ack   <= cmd_hit;
            vid_rdata <= (vid_hit && !vid_req_write) ? vid_req_addr ^ 32'h5a5a_5a5a : ~vid_rdata;
            cmd_rdata <= cmd_hit ? cmd_req_addr ^ 32'h5a5a_5a5a : ~cmd_rdata;
        end
    end
endmodule // sys_mem_model

// File: bench/dual_channel_bus_master_dma_tb.sv
/*
 Self-checking bench for the two-channel DMA engine.
 Assumes the memory model and the shared register map.
*/
`timescale 1ns/1ps
`include "dma_defines.vh"
module dual_channel_bus_master_dma_tb;
    reg         ref_clk = 1'b0, rstn = 1'b0, clk_en = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
    reg         port_ready = 1'b0, engine_ready = 1'b0, vmem_valid = 1'b0;
    reg  [15:0] reg_addr = 16'h0, a;
    reg  [31:0] reg_wdata = 32'h0, vmem_data = 32'h0, r, st, base, rr;
    reg  [31:0] vd [0:1];
    wire [31:0] reg_rdata, vid_req_addr, vid_req_wdata, vid_rdata, cmd_req_addr, cmd_rdata, port_data, engine_data;
    wire        vid_req, vid_req_write, vid_ack, cmd_req, cmd_ack, port_valid, port_to_video, port_decimate;
    wire        vmem_ready, engine_valid, irq;
    integer     miscompares = 0, checks = 0, seed = 32'ha15de544, i, k, n;
    reg  [31:0] pq[$], eq[$], wq[$], dq[$];
    dual_channel_bus_master_dma dut (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .vid_req(vid_req),
        .vid_req_write(vid_req_write), .vid_req_addr(vid_req_addr), .vid_req_wdata(vid_req_wdata), .vid_ack(vid_ack),
        .vid_rdata(vid_rdata), .cmd_req(cmd_req), .cmd_req_addr(cmd_req_addr), .cmd_ack(cmd_ack),
        .cmd_rdata(cmd_rdata), .port_valid(port_valid), .port_data(port_data), .port_to_video(port_to_video),
        .port_decimate(port_decimate), .port_ready(port_ready), .vmem_valid(vmem_valid), .vmem_data(vmem_data),
        .vmem_ready(vmem_ready), .engine_valid(engine_valid), .engine_data(engine_data),
        .engine_ready(engine_ready), .irq(irq));
    sys_mem_model u_mem (.ref_clk(ref_clk), .rstn(rstn), .vid_req(vid_req), .vid_req_write(vid_req_write),
        .vid_req_addr(vid_req_addr), .vid_ack(vid_ack), .vid_rdata(vid_rdata), .cmd_req(cmd_req),
        .cmd_req_addr(cmd_req_addr), .cmd_ack(cmd_ack), .cmd_rdata(cmd_rdata));
    // 100 MHz clock.
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    function [31:0] mem(input [31:0] ad);
        mem = ad ^ 32'h5a5a_5a5a;
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [15:0] ad, input [31:0] v);
        begin
            @(posedge ref_clk);
            reg_addr <= ad;
            reg_wdata <= v;
            reg_write <= 1'b1;
            @(posedge ref_clk);
            reg_write <= 1'b0;
        end
    endtask
    // Read data stand one cycle only, so sample just past that edge.
    task rd(input [15:0] ad);
        begin
            @(posedge ref_clk);
            reg_addr <= ad;
            reg_read <= 1'b1;
            @(posedge ref_clk);
            reg_read <= 1'b0;
            #1 r = reg_rdata;
        end
    endtask
    task poll(input [15:0] ad, input [31:0] m, input [31:0] e);
        begin
            rd(ad);
            for (n = 0; n < 300 && (r & m) !== e; n = n + 1) rd(ad);
            chk(r & m, e);
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d miscompares %0d", checks, miscompares);
            if (miscompares == 0 && checks > 0) $display("All tests passed");
            else $display("Some tests failed");
            $finish;
        end
    endtask
    // Random back-pressure on both output streams.
    always @(posedge ref_clk) begin
        rr = $random(seed);
        port_ready <= rr[0];
        engine_ready <= rr[1];
    end
    // Handshakes are judged at the falling edge, once settled.
    always @(negedge ref_clk) begin
        if (port_valid && port_ready) chk(port_data, pq.pop_front());
        if (engine_valid && engine_ready) chk(engine_data, eq.pop_front());
        if (vid_ack && vid_req_write) chk(vid_req_addr, wq.pop_front());
        if (vid_ack && vid_req_write) chk(vid_req_wdata, dq.pop_front());
    end
    // A hang ends the run through the normal closing path.
    initial begin
        #100000;
        miscompares = miscompares + 1;
        end_sim;
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
        for (a = 16'h8580; a < 16'h85ac; a = a + 16'h4) poll(a, 32'hffff_ffff, 32'h0);
        st = $random(seed) & 32'hffff_fffc;
        k = ($random(seed) & 3) + 2;
        for (i = 0; i < k; i = i + 1) pq.push_back(mem(st + 4 * i));
        wr(`ADDR_DMA_CONTROL, 32'h0000_001b);
        wr(`ADDR_VIDEO_START, st);
        wr(`ADDR_VIDEO_LENGTH, (k - 1) << 2);
        base = $random(seed) & 32'hffff_f000;
        wr(`ADDR_CMD_BASE, base);
        wr(`ADDR_CMD_READ_PTR, 32'h0000_0ff8);
        wr(`ADDR_CMD_WRITE_PTR, 32'h0001_0004);
        poll(`ADDR_CMD_READ_PTR, 32'hfffc, 32'h0ff8);
        for (i = 0; i < 3; i = i + 1) eq.push_back(mem(base | ((32'hff8 + 4 * i) & 32'hffc)));
        wr(`ADDR_CMD_ENABLE, 32'h1);
        wr(`ADDR_VIDEO_ENABLE, 32'h1);
        poll(`ADDR_VIDEO_ENABLE, 32'h1, 32'h0);
        poll(`ADDR_CMD_READ_PTR, 32'hffc, 32'h004);
        poll(`ADDR_DMA_STATUS, 32'h3, 32'h3);
        chk({29'h0, irq, port_to_video, port_decimate}, 32'h7);
        wr(`ADDR_DMA_STATUS, 32'h3);
        poll(`ADDR_DMA_STATUS, 32'h3, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr(`ADDR_CMD_WRITE_PTR, 32'h0000_0100);
        poll(`ADDR_CMD_WRITE_PTR, 32'hfffc, 32'h0004);
        wr(`ADDR_CMD_ENABLE, 32'h0);
        base = $random(seed) & 32'hffff_0000;
        wr(`ADDR_CMD_BASE, base | 32'h2);
        wr(`ADDR_CMD_READ_PTR, 32'h0000_1ffc);
        for (i = 0; i < 2; i = i + 1) eq.push_back(mem(base + 32'h1ffc + 4 * i));
        wr(`ADDR_CMD_WRITE_PTR, 32'h0001_2004);
        wr(`ADDR_CMD_ENABLE, 32'h1);
        poll(`ADDR_CMD_READ_PTR, 32'hfffc, 32'h2004);
        st = $random(seed) & 32'hffff_fffc;
        for (i = 0; i < 2; i = i + 1) vd[i] = $random(seed);
        for (i = 0; i < 2; i = i + 1) wq.push_back(st + 4 * i);
        for (i = 0; i < 2; i = i + 1) dq.push_back(vd[i]);
        wr(`ADDR_VIDEO_START, st | 32'h2);
        wr(`ADDR_VIDEO_LENGTH, 32'h4);
        wr(`ADDR_VIDEO_ENABLE, 32'h1);
        @(posedge ref_clk);
        vmem_valid <= 1'b1;
        vmem_data <= vd[0];
        for (i = 0; i < 2; i = i + 1) begin
            @(negedge ref_clk);
            for (n = 0; n < 100 && vmem_ready !== 1'b1; n = n + 1) @(negedge ref_clk);
            @(posedge ref_clk);
            vmem_valid <= (i == 0);
            vmem_data <= (i == 0) ? vd[1] : ~vd[1];
        end
        poll(`ADDR_VIDEO_ENABLE, 32'h1, 32'h0);
        wr(`ADDR_CMD_ENABLE, 32'h0);
        wr(`ADDR_DMA_CONTROL, 32'h4);
        poll(`ADDR_CMD_READ_PTR, 32'hfffc, 32'h0);
        wr(`ADDR_DMA_CONTROL, 32'h0);
        for (n = 0; n < 100 && pq.size() + eq.size() + wq.size() > 0; n = n + 1) @(posedge ref_clk);
        chk(pq.size() + eq.size() + wq.size(), 32'h0);
        end_sim;
    end
endmodule // dual_channel_bus_master_dma_tb
